/* core/addr_mode_decode.sv */
// Operand addressing-mode decoder and effective-address former
`timescale 1ns/100ps
`include "addr_mode_map.svh"
module addr_mode_decode (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // Instruction from the fetch path
  input  wire logic                       insn_valid,
  input  wire logic [7:0]                 insn_prefix,
  input  wire logic [7:0]                 insn_opcode,
  input  wire logic [15:0]                insn_pc,
  input  wire logic [7:0]                 index_value,
  // Operand and pointer bytes, in instruction order
  input  wire logic                       byte_valid,
  input  wire logic [7:0]                 byte_data,
  // Memory bus read of pointer bytes
  output logic                            ptr_rd,
  output logic [15:0]                     ptr_addr,
  input  wire logic                       ptr_ack,
  input  wire logic [7:0]                 ptr_data,
  // Result
  output logic                            busy,
  output logic                            ea_valid,
  output logic [15:0]                     ea,
  output addr_mode_pkg::addr_mode_t       mode,
  output addr_mode_pkg::mode_group_t      group,
  output logic                            is_long,
  output logic                            mode_fault
);
  // ========================================================================
  // Classification
  mode_class_if cls ();

  opcode_classifier classifier (
    .prefix (insn_prefix),
    .opcode (insn_opcode),
    .cls    (cls.producer)
  );

  // ========================================================================
  // Address arithmetic
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] disp);
    rel_target = pc + {{8{disp[7]}}, disp};
  endfunction

  function automatic logic [15:0] add_index(input logic [15:0] base, input logic [7:0] idx);
    add_index = base + {8'h00, idx};
  endfunction

  // ========================================================================
  // Fetch sequencer
  addr_mode_pkg::fetch_state_t state;
  addr_mode_pkg::fetch_state_t next_state;
  addr_mode_pkg::addr_mode_t   held_mode;
  addr_mode_pkg::mode_group_t  held_group;
  logic                        held_long;
  logic [1:0]                  bytes_left;
  logic [15:0]                 operand;
  logic [15:0]                 pc_hold;
  logic [7:0]                  idx_hold;

  wire logic is_indirect =
    (held_mode == addr_mode_pkg::MODE_SHORT_INDIRECT) ||
    (held_mode == addr_mode_pkg::MODE_LONG_INDIRECT) ||
    (held_mode == addr_mode_pkg::MODE_SHORT_INDIRECT_INDEXED) ||
    (held_mode == addr_mode_pkg::MODE_LONG_INDIRECT_INDEXED) ||
    (held_mode == addr_mode_pkg::MODE_RELATIVE_INDIRECT) ||
    (held_mode == addr_mode_pkg::MODE_BIT_INDIRECT) ||
    (held_mode == addr_mode_pkg::MODE_BIT_INDIRECT_RELATIVE);
  wire logic is_indexed =
    (held_mode == addr_mode_pkg::MODE_NO_OFFSET_INDEXED) ||
    (held_mode == addr_mode_pkg::MODE_SHORT_INDEXED) ||
    (held_mode == addr_mode_pkg::MODE_LONG_INDEXED) ||
    (held_mode == addr_mode_pkg::MODE_SHORT_INDIRECT_INDEXED) ||
    (held_mode == addr_mode_pkg::MODE_LONG_INDIRECT_INDEXED);
  wire logic is_relative =
    (held_mode == addr_mode_pkg::MODE_RELATIVE_DIRECT) ||
    (held_mode == addr_mode_pkg::MODE_RELATIVE_INDIRECT);
  // Long indirect reads a word pointer; short indirect a byte pointer
  wire logic word_ptr = held_long && is_indirect;

  // ========================================================================
  // State decodes shared by the sequencer and the datapath
  wire logic in_idle     = (state == addr_mode_pkg::ST_IDLE);
  wire logic in_operand  = (state == addr_mode_pkg::ST_OPERAND);
  wire logic in_ptr_high = (state == addr_mode_pkg::ST_POINTER_HIGH);
  wire logic in_ptr_low  = (state == addr_mode_pkg::ST_POINTER_LOW);
  wire logic in_done     = (state == addr_mode_pkg::ST_DONE);
  wire logic last_byte   = in_operand && byte_valid && (bytes_left == 2'h1);
  // The first pointer read leaves with the last operand byte, saving a cycle
  wire logic ptr_launch  = last_byte && is_indirect;
  wire logic ptr_follow  = in_ptr_high && ptr_ack && word_ptr;
  // Result pulse marks the edge that enters the final state, once per instruction
  wire logic done_entry  = (next_state == addr_mode_pkg::ST_DONE) && !in_done;

  // ========================================================================
  // Effective address
  // Short forms stay on page zero; short indexed may carry past 00FFh by the index
  // Every long form keeps all 16 bits, the word read through a long pointer too
  wire logic [15:0] short_base = {`PAGE_ZERO_HIGH, operand[7:0]};
  wire logic [15:0] base_addr  = held_long ? operand : short_base;
  wire logic [15:0] direct_ea  = is_indexed ? add_index(base_addr, idx_hold) : base_addr;
  wire logic [15:0] rel_ea     = rel_target(pc_hold, operand[7:0]);
  wire logic [15:0] result_ea  = is_relative ? rel_ea : direct_ea;
  wire logic        accept     = insn_valid && in_idle;
  // Read-modify-write on memory takes no long form
  wire logic        rmw_long   = cls.is_rmw && cls.is_long;
  wire logic        bad_insn   = cls.illegal || rmw_long;
  wire logic        no_operand = (cls.operand_bytes == 2'h0);
  wire logic [15:0] ptr_next   = {`PAGE_ZERO_HIGH, operand[7:0]} + 16'h0001;

  // ========================================================================
  // Next-state logic
  always_comb begin
    next_state = state;
    case (state)
      addr_mode_pkg::ST_IDLE:
        if (accept && !bad_insn) begin
          next_state = no_operand ? addr_mode_pkg::ST_DONE : addr_mode_pkg::ST_OPERAND;
        end
      addr_mode_pkg::ST_OPERAND:
        if (last_byte) begin
          next_state = is_indirect ? addr_mode_pkg::ST_POINTER_HIGH : addr_mode_pkg::ST_DONE;
        end
      addr_mode_pkg::ST_POINTER_HIGH:
        if (ptr_ack) begin
          next_state = word_ptr ? addr_mode_pkg::ST_POINTER_LOW : addr_mode_pkg::ST_DONE;
        end
      addr_mode_pkg::ST_POINTER_LOW:
        if (ptr_ack) begin
          next_state = addr_mode_pkg::ST_DONE;
        end
      addr_mode_pkg::ST_DONE:
        next_state = addr_mode_pkg::ST_IDLE;
      default:
        next_state = addr_mode_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= addr_mode_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Held instruction context
  // Capture classification and context with the instruction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_mode  <= addr_mode_pkg::MODE_INHERENT;
      held_group <= addr_mode_pkg::GROUP_INHERENT;
      held_long  <= 1'b0;
      pc_hold    <= 16'h0000;
      idx_hold   <= 8'h00;
    end else if (accept) begin
      held_mode  <= cls.mode;
      held_group <= cls.group;
      held_long  <= cls.is_long;
      pc_hold    <= insn_pc;
      idx_hold   <= index_value;
    end
  end

  // Operand bytes shift in high first; pointer bytes replace them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      operand    <= 16'h0000;
      bytes_left <= 2'h0;
    end else if (accept) begin
      operand    <= 16'h0000;
      bytes_left <= cls.operand_bytes;
    end else if (in_operand && byte_valid) begin
      operand    <= {operand[7:0], byte_data};
      bytes_left <= bytes_left - 2'h1;
    end else if (in_ptr_high && ptr_ack) begin
      operand    <= word_ptr ? {ptr_data, 8'h00} : {8'h00, ptr_data};
    end else if (in_ptr_low && ptr_ack) begin
      operand    <= {operand[15:8], ptr_data};
    end
  end

  // ========================================================================
  // Pointer reads
  // Pointer reads start in page zero, so the pointer itself is short; a word pointer at 00FFh reads its second byte from 0100h
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_rd   <= 1'b0;
      ptr_addr <= 16'h0000;
    end else if (ptr_launch) begin
      ptr_rd   <= 1'b1;
      ptr_addr <= {`PAGE_ZERO_HIGH, byte_data};
    end else if (ptr_follow) begin
      ptr_rd   <= 1'b1;
      ptr_addr <= ptr_next;
    end else if (ptr_ack) begin
      ptr_rd   <= 1'b0;
    end
  end

  // ========================================================================
  // Results
  // Fields change one edge after the pulse and stand until the next result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ea_valid   <= 1'b0;
      ea         <= 16'h0000;
      mode       <= addr_mode_pkg::MODE_INHERENT;
      group      <= addr_mode_pkg::GROUP_INHERENT;
      is_long    <= 1'b0;
      mode_fault <= 1'b0;
      busy       <= 1'b0;
    end else begin
      ea_valid   <= done_entry;
      mode_fault <= accept && bad_insn;
      busy       <= next_state != addr_mode_pkg::ST_IDLE;
      if (in_done) begin
        mode    <= held_mode;
        group   <= held_group;
        is_long <= held_long;
        ea      <= result_ea;
      end
    end
  end
endmodule

/* shared/addr_mode_map.svh */
// Constants for the operand addressing-mode decoder
`ifndef ADDR_MODE_MAP_SVH
`define ADDR_MODE_MAP_SVH

// ==========================================================================
// Mode counts and address limits
`define MODE_COUNT      5'h11
`define PAGE_ZERO_LAST  16'h00FF
`define PAGE_ZERO_HIGH  8'h00

// ==========================================================================
// Prefix bytes that steer the indirect and index-register variants
`define PREFIX_INDIRECT 8'h92
`define PREFIX_Y_INDEX  8'h90
`define PREFIX_Y_INDIR  8'h91

// ==========================================================================
// High-nibble opcode columns
`define COL_BIT_REL     4'h0
`define COL_BIT_OP      4'h1
`define COL_RELATIVE    4'h2
`define COL_RMW_SHORT   4'h3
`define COL_RMW_INH_A   4'h4
`define COL_RMW_INH_X   4'h5
`define COL_RMW_IDX1    4'h6
`define COL_RMW_IDX0    4'h7
`define COL_INHERENT    4'h8
`define COL_INHERENT2   4'h9
`define COL_IMMEDIATE   4'hA
`define COL_DIRECT      4'hB
`define COL_LONG        4'hC
`define COL_LONG_IDX    4'hD
`define COL_SHORT_IDX   4'hE
`define COL_NO_OFFSET   4'hF

`endif

/* shared/addr_mode_pkg.sv */
// Types for the operand addressing-mode decoder
package addr_mode_pkg;

  typedef enum logic [4:0] {
    MODE_INHERENT,
    MODE_IMMEDIATE,
    MODE_SHORT_DIRECT,
    MODE_LONG_DIRECT,
    MODE_NO_OFFSET_INDEXED,
    MODE_SHORT_INDEXED,
    MODE_LONG_INDEXED,
    MODE_SHORT_INDIRECT,
    MODE_LONG_INDIRECT,
    MODE_SHORT_INDIRECT_INDEXED,
    MODE_LONG_INDIRECT_INDEXED,
    MODE_RELATIVE_DIRECT,
    MODE_RELATIVE_INDIRECT,
    MODE_BIT_DIRECT,
    MODE_BIT_INDIRECT,
    MODE_BIT_DIRECT_RELATIVE,
    MODE_BIT_INDIRECT_RELATIVE
  } addr_mode_t;

  typedef enum logic [2:0] {
    GROUP_INHERENT,
    GROUP_IMMEDIATE,
    GROUP_DIRECT,
    GROUP_INDEXED,
    GROUP_INDIRECT,
    GROUP_RELATIVE,
    GROUP_BIT
  } mode_group_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPERAND,
    ST_POINTER_HIGH,
    ST_POINTER_LOW,
    ST_DONE
  } fetch_state_t;

endpackage

/* shared/mode_class_if.sv */
// Classification result passed from the opcode classifier to the address former
`timescale 1ns/100ps
interface mode_class_if;
  addr_mode_pkg::addr_mode_t  mode;
  addr_mode_pkg::mode_group_t group;
  logic                       is_long;
  logic                       is_rmw;
  logic                       illegal;
  logic [1:0]                 operand_bytes;

  modport producer (
    output mode,
    output group,
    output is_long,
    output is_rmw,
    output illegal,
    output operand_bytes
  );
  modport consumer (
    input mode,
    input group,
    input is_long,
    input is_rmw,
    input illegal,
    input operand_bytes
  );
endinterface

/* core/opcode_classifier.sv */
// Combinational opcode classifier: mode, group, variant and operand length
`timescale 1ns/100ps
`include "addr_mode_map.svh"
module opcode_classifier (
  // Instruction bytes
  input  wire logic [7:0] prefix,
  input  wire logic [7:0] opcode,
  // Classification
  mode_class_if.producer  cls
);
  wire logic [3:0] column   = opcode[7:4];
  wire logic       indirect = (prefix == `PREFIX_INDIRECT) || (prefix == `PREFIX_Y_INDIR);

  // RMW columns 3, 6 and 7 carry memory operands; 4 and 5 work on registers
  wire logic rmw_mem = (column == `COL_RMW_SHORT) || (column == `COL_RMW_IDX1) ||
                       (column == `COL_RMW_IDX0);

  always_comb begin
    cls.mode          = addr_mode_pkg::MODE_INHERENT;
    cls.group         = addr_mode_pkg::GROUP_INHERENT;
    cls.is_long       = 1'b0;
    cls.is_rmw        = rmw_mem;
    cls.illegal       = 1'b0;
    cls.operand_bytes = 2'h0;
    case (column)
      `COL_BIT_REL: begin
        cls.group         = addr_mode_pkg::GROUP_BIT;
        cls.mode          = indirect ? addr_mode_pkg::MODE_BIT_INDIRECT_RELATIVE
                                     : addr_mode_pkg::MODE_BIT_DIRECT_RELATIVE;
        cls.operand_bytes = 2'h2;
      end
      `COL_BIT_OP: begin
        cls.group         = addr_mode_pkg::GROUP_BIT;
        cls.mode          = indirect ? addr_mode_pkg::MODE_BIT_INDIRECT
                                     : addr_mode_pkg::MODE_BIT_DIRECT;
        cls.operand_bytes = 2'h1;
      end
      `COL_RELATIVE: begin
        cls.group         = addr_mode_pkg::GROUP_RELATIVE;
        cls.mode          = indirect ? addr_mode_pkg::MODE_RELATIVE_INDIRECT
                                     : addr_mode_pkg::MODE_RELATIVE_DIRECT;
        cls.operand_bytes = 2'h1;
      end
      `COL_RMW_SHORT, `COL_DIRECT: begin
        cls.group         = indirect ? addr_mode_pkg::GROUP_INDIRECT
                                     : addr_mode_pkg::GROUP_DIRECT;
        cls.mode          = indirect ? addr_mode_pkg::MODE_SHORT_INDIRECT
                                     : addr_mode_pkg::MODE_SHORT_DIRECT;
        cls.operand_bytes = 2'h1;
      end
      `COL_RMW_IDX1, `COL_SHORT_IDX: begin
        cls.group         = indirect ? addr_mode_pkg::GROUP_INDIRECT
                                     : addr_mode_pkg::GROUP_INDEXED;
        cls.mode          = indirect ? addr_mode_pkg::MODE_SHORT_INDIRECT_INDEXED
                                     : addr_mode_pkg::MODE_SHORT_INDEXED;
        cls.operand_bytes = 2'h1;
      end
      `COL_RMW_IDX0, `COL_NO_OFFSET: begin
        cls.group   = addr_mode_pkg::GROUP_INDEXED;
        cls.mode    = addr_mode_pkg::MODE_NO_OFFSET_INDEXED;
        cls.illegal = indirect;
      end
      `COL_IMMEDIATE: begin
        cls.group         = addr_mode_pkg::GROUP_IMMEDIATE;
        cls.mode          = addr_mode_pkg::MODE_IMMEDIATE;
        cls.operand_bytes = 2'h1;
        cls.illegal       = indirect;
      end
      `COL_LONG: begin
        cls.is_long       = 1'b1;
        cls.group         = indirect ? addr_mode_pkg::GROUP_INDIRECT
                                     : addr_mode_pkg::GROUP_DIRECT;
        cls.mode          = indirect ? addr_mode_pkg::MODE_LONG_INDIRECT
                                     : addr_mode_pkg::MODE_LONG_DIRECT;
        cls.operand_bytes = indirect ? 2'h1 : 2'h2;
      end
      `COL_LONG_IDX: begin
        cls.is_long       = 1'b1;
        cls.group         = indirect ? addr_mode_pkg::GROUP_INDIRECT
                                     : addr_mode_pkg::GROUP_INDEXED;
        cls.mode          = indirect ? addr_mode_pkg::MODE_LONG_INDIRECT_INDEXED
                                     : addr_mode_pkg::MODE_LONG_INDEXED;
        cls.operand_bytes = indirect ? 2'h1 : 2'h2;
      end
      default: begin
        cls.illegal = indirect;
      end
    endcase
  end
endmodule

/* bench/ptr_mem_model.sv */
// Memory bus model that answers pointer reads from page zero
`timescale 1ns/100ps
module ptr_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Answer pace
  input  wire logic        slow,
  // Pointer read bus
  input  wire logic        ptr_rd,
  input  wire logic [15:0] ptr_addr,
  output logic             ptr_ack,
  output logic [7:0]       ptr_data
);
  logic [2:0] wait_cnt;
  wire        want = ptr_rd && !ptr_ack;
  wire        go   = want && (wait_cnt >= (slow ? 3'h4 : 3'h0));

  // ==========================================================
  // Answer
  // Contents depend on the low address byte only: page zero pointers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_ack  <= 1'b0;
      ptr_data <= 8'h00;
      wait_cnt <= 3'h0;
    end else if (go) begin
      ptr_ack  <= 1'b1;
      ptr_data <= ptr_addr[7:0] ^ 8'hA5;
      wait_cnt <= 3'h0;
    end else begin
      // Data line is not held after the answer, so it keeps changing
      ptr_ack  <= 1'b0;
      ptr_data <= ~ptr_data;
      if (want) wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule

/* bench/addr_mode_decode_properties.sv */
// Concurrent checks on the ports of the addressing-mode decoder
`timescale 1ns/100ps
module addr_mode_decode_properties (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset_n,
  // Watched ports
  input wire logic                  busy,
  input wire logic                  ptr_rd,
  input wire logic [15:0]           ptr_addr,
  input wire logic                  ptr_ack,
  input wire logic                  ea_valid,
  input wire logic [15:0]           ea,
  input addr_mode_pkg::addr_mode_t  mode,
  input addr_mode_pkg::mode_group_t group,
  input wire logic                  is_long,
  input wire logic                  mode_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Result fields land one edge after the valid pulse
  sequence s_result;
    ea_valid ##1 1'b1;
  endsequence

  wire short_mode = mode inside {addr_mode_pkg::MODE_SHORT_DIRECT,
    addr_mode_pkg::MODE_NO_OFFSET_INDEXED, addr_mode_pkg::MODE_SHORT_INDIRECT,
    addr_mode_pkg::MODE_BIT_DIRECT};
  wire long_mode = mode inside {addr_mode_pkg::MODE_LONG_DIRECT,
    addr_mode_pkg::MODE_LONG_INDEXED, addr_mode_pkg::MODE_LONG_INDIRECT,
    addr_mode_pkg::MODE_LONG_INDIRECT_INDEXED};
  wire rel_mode = mode inside {addr_mode_pkg::MODE_RELATIVE_DIRECT,
    addr_mode_pkg::MODE_RELATIVE_INDIRECT};

  AST_PTR_PAGE_ZERO: assert property (ptr_rd |-> ptr_addr[15:8] == 8'h00)
    else $error("pointer read outside page zero");
  AST_PTR_HOLD: assert property (ptr_rd && !ptr_ack |=> ptr_rd && $stable(ptr_addr))
    else $error("pointer read dropped before answer");
  AST_NO_PTR_IDLE: assert property (!busy |-> !ptr_rd)
    else $error("pointer read while idle");
  AST_EA_PULSE: assert property (ea_valid |=> !ea_valid)
    else $error("result pulse longer than one cycle");
  AST_FAULT_ALONE: assert property (mode_fault |-> !ea_valid ##1 !mode_fault)
    else $error("fault pulse with result or too long");
  AST_SHORT_PAGE: assert property (s_result |-> !short_mode || ea[15:8] == 8'h00)
    else $error("short form left page zero");
  AST_LONG_FLAG: assert property (s_result |-> is_long == long_mode)
    else $error("long flag does not match mode");
  AST_REL_GROUP: assert property (s_result |-> (group == addr_mode_pkg::GROUP_RELATIVE) == rel_mode)
    else $error("relative group does not match mode");
endmodule

bind addr_mode_decode addr_mode_decode_properties addr_mode_decode_properties_i (
  .clk(clk), .reset_n(reset_n), .busy(busy), .ptr_rd(ptr_rd), .ptr_addr(ptr_addr),
  .ptr_ack(ptr_ack), .ea_valid(ea_valid), .ea(ea), .mode(mode), .group(group),
  .is_long(is_long), .mode_fault(mode_fault));

/* bench/cpu_addressing_mode_decode_tb.sv */
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/100ps
module cpu_addressing_mode_decode_tb;
  logic clk = 1'b0, reset_n = 1'b0, slow = 1'b0;
  logic insn_valid = 1'b0, byte_valid = 1'b0, ptr_rd, ptr_ack, busy, ea_valid, is_long, mode_fault;
  logic [7:0] insn_prefix = 8'h00, insn_opcode = 8'h9D, index_value = 8'h00;
  logic [7:0] byte_data = 8'h00, ptr_data;
  logic [15:0] insn_pc = 16'h0000, ptr_addr, ea;
  addr_mode_pkg::addr_mode_t mode;
  addr_mode_pkg::mode_group_t group;
  logic [15:0] res_ea;
  logic [15:0] res_mode, res_group;
  logic res_long, res_fault, res_done;
  int mismatches = 0, samples_checked = 0;

  always #25 clk = ~clk;

  addr_mode_decode addr_mode_decode_i (.clk(clk), .reset_n(reset_n), .insn_valid(insn_valid),
    .insn_prefix(insn_prefix), .insn_opcode(insn_opcode), .insn_pc(insn_pc),
    .index_value(index_value), .byte_valid(byte_valid), .byte_data(byte_data),
    .ptr_rd(ptr_rd), .ptr_addr(ptr_addr), .ptr_ack(ptr_ack), .ptr_data(ptr_data),
    .busy(busy), .ea_valid(ea_valid), .ea(ea), .mode(mode), .group(group),
    .is_long(is_long), .mode_fault(mode_fault));
  ptr_mem_model ptr_mem_model_i (.clk(clk), .reset_n(reset_n), .slow(slow), .ptr_rd(ptr_rd),
    .ptr_addr(ptr_addr), .ptr_ack(ptr_ack), .ptr_data(ptr_data));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One instruction: offer it, feed operand bytes back to back, wait for the answer
  task automatic run(input logic [7:0] pfx, input logic [7:0] opc, input logic [15:0] pc,
                     input logic [7:0] idx, input logic [7:0] b0, input logic [7:0] b1,
                     input int n);
    int k;
    logic seen;
    seen = 1'b0;
    res_fault = 1'b0;
    res_done = 1'b0;
    @(negedge clk);
    insn_prefix = pfx;
    insn_opcode = opc;
    insn_pc = pc;
    index_value = idx;
    insn_valid = 1'b1;
    @(negedge clk);
    insn_valid = 1'b0;
    for (k = 0; k < 60 && !seen; k++) begin
      res_fault = (mode_fault === 1'b1);
      res_done = (ea_valid === 1'b1);
      seen = res_fault || res_done;
      if (!seen) begin
        byte_valid = (k < n);
        byte_data = (k == 0) ? b0 : b1;
        @(negedge clk);
      end
    end
    byte_valid = 1'b0;
    byte_data = ~byte_data;
    if (!seen) check(16'h0000, 16'h0001);
    @(negedge clk);
    res_ea = ea;
    res_mode = {11'h000, mode};
    res_group = {13'h0000, group};
    res_long = is_long;
    repeat (2) @(negedge clk);
  endtask

  task automatic expect_result(input addr_mode_pkg::addr_mode_t m,
                               input addr_mode_pkg::mode_group_t g, input logic l,
                               input logic [15:0] e);
    check({15'h0000, res_done}, 16'h0001);
    check(res_mode, {11'h000, m});
    check(res_group, {13'h0000, g});
    check({15'h0000, res_long}, {15'h0000, l});
    check(res_ea, e);
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_short_forms;
    run(8'h00, 8'hB6, 16'h0000, 8'h00, 8'h10, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_SHORT_DIRECT, addr_mode_pkg::GROUP_DIRECT, 1'b0, 16'h0010);
    run(8'h00, 8'hE6, 16'h0000, 8'hFF, 8'hF0, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_SHORT_INDEXED, addr_mode_pkg::GROUP_INDEXED, 1'b0, 16'h01EF);
    run(8'h00, 8'hF6, 16'h0000, 8'h33, 8'h00, 8'h00, 0);
    expect_result(addr_mode_pkg::MODE_NO_OFFSET_INDEXED, addr_mode_pkg::GROUP_INDEXED, 1'b0, 16'h0033);
    $display("test short_forms done");
  endtask

  task automatic test_long_forms;
    run(8'h00, 8'hC6, 16'h0000, 8'h00, 8'hFE, 8'h34, 2);
    expect_result(addr_mode_pkg::MODE_LONG_DIRECT, addr_mode_pkg::GROUP_DIRECT, 1'b1, 16'hFE34);
    run(8'h00, 8'hD6, 16'h0000, 8'h20, 8'h12, 8'hF0, 2);
    expect_result(addr_mode_pkg::MODE_LONG_INDEXED, addr_mode_pkg::GROUP_INDEXED, 1'b1, 16'h1310);
    $display("test long_forms done");
  endtask

  // Pointer contents follow the model: low address byte xor A5h
  task automatic test_indirect;
    slow = 1'b1;
    run(8'h92, 8'hB6, 16'h0000, 8'h00, 8'h40, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_SHORT_INDIRECT, addr_mode_pkg::GROUP_INDIRECT, 1'b0, 16'h00E5);
    slow = 1'b0;
    run(8'h92, 8'hC6, 16'h0000, 8'h00, 8'h50, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_LONG_INDIRECT, addr_mode_pkg::GROUP_INDIRECT, 1'b1, 16'hF5F4);
    $display("test indirect done");
  endtask

  // Extreme displacements in both directions
  task automatic test_relative;
    run(8'h00, 8'h27, 16'h1000, 8'h00, 8'h7F, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_RELATIVE_DIRECT, addr_mode_pkg::GROUP_RELATIVE, 1'b0, 16'h107F);
    run(8'h00, 8'h27, 16'h1000, 8'h00, 8'h80, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_RELATIVE_DIRECT, addr_mode_pkg::GROUP_RELATIVE, 1'b0, 16'h0F80);
    $display("test relative done");
  endtask

  // Indirect indexed, relative indirect and bit direct forms; pointers follow the model
  task automatic test_more_forms;
    run(8'h91, 8'hE6, 16'h0000, 8'h80, 8'h30, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_SHORT_INDIRECT_INDEXED,
                  addr_mode_pkg::GROUP_INDIRECT, 1'b0, 16'h0115);
    run(8'h92, 8'hD6, 16'h0000, 8'h10, 8'h60, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_LONG_INDIRECT_INDEXED,
                  addr_mode_pkg::GROUP_INDIRECT, 1'b1, 16'hC5D4);
    run(8'h92, 8'h27, 16'h2000, 8'h00, 8'h2A, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_RELATIVE_INDIRECT,
                  addr_mode_pkg::GROUP_RELATIVE, 1'b0, 16'h1F8F);
    run(8'h00, 8'h14, 16'h0000, 8'h00, 8'h7E, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_BIT_DIRECT,
                  addr_mode_pkg::GROUP_BIT, 1'b0, 16'h007E);
    $display("test more_forms done");
  endtask

  task automatic test_rmw_and_fault;
    run(8'h00, 8'h3C, 16'h0000, 8'h00, 8'h20, 8'h00, 1);
    expect_result(addr_mode_pkg::MODE_SHORT_DIRECT, addr_mode_pkg::GROUP_DIRECT, 1'b0, 16'h0020);
    run(8'h92, 8'hA6, 16'h0000, 8'h00, 8'h55, 8'h00, 1);
    check({15'h0000, res_fault}, 16'h0001);
    check({15'h0000, res_done}, 16'h0000);
    run(8'h00, 8'h9D, 16'h0000, 8'h00, 8'h00, 8'h00, 0);
    check(res_mode, {11'h000, addr_mode_pkg::MODE_INHERENT});
    run(8'h00, 8'hA6, 16'h0000, 8'h00, 8'h55, 8'h00, 1);
    check(res_group, {13'h0000, addr_mode_pkg::GROUP_IMMEDIATE});
    $display("test rmw_and_fault done");
  endtask

  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    test_short_forms;
    test_long_forms;
    test_indirect;
    test_relative;
    test_more_forms;
    test_rmw_and_fault;
    complete_run;
  end

  // 17 instructions of under 20 cycles each; far more is a hang
  initial begin
    #(50 * 5000);
    mismatches++;
    complete_run;
  end
endmodule
